// ==== aot_fuse_loader.sv ====
// Purpose: Walks fuse storage once per start and loads each trim word.
// Assumes: Fuse storage answers on the same clock, data valid one cycle after a read.
// Notes:   Two cycles per word; busy stays high until the last word is written.
`timescale 1ns/10ps
module aot_fuse_loader
  import aot_pkg::*;
#(
  parameter int NUM_WORDS = NUM_FUSE
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // Control
  input  wire logic                   start,
  output logic                        busy,
  // Fuse storage port
  output logic [FUSE_ADDR_W-1:0]      fuseAddr,
  output logic                        fuseRdEn,
  input  wire logic [FUSE_W-1:0]      fuseData,
  // Register load port
  output logic                        loadWe,
  output logic [SLOT_W-1:0]           loadSlot,
  output logic [FUSE_W-1:0]           loadData
);

  typedef enum logic [1:0] {LD_IDLE, LD_FETCH, LD_CAPTURE} aot_load_e;

  aot_load_e                state_q;
  logic [FUSE_ADDR_W-1:0]   index_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= LD_IDLE;
      index_q <= '0;
    end else begin
      case (state_q)
        LD_IDLE: begin
          if (start) begin
            state_q <= LD_FETCH;
            index_q <= '0;
          end
        end
        LD_FETCH: begin
          state_q <= LD_CAPTURE;
        end
        LD_CAPTURE: begin
          if (index_q == FUSE_ADDR_W'(NUM_WORDS - 1)) begin
            state_q <= LD_IDLE;
          end else begin
            index_q <= index_q + 3'h1;
            state_q <= LD_FETCH;
          end
        end
        default: begin
          state_q <= LD_IDLE;
        end
      endcase
    end
  end

  assign busy     = (state_q != LD_IDLE);
  assign fuseAddr = index_q;
  assign fuseRdEn = (state_q == LD_FETCH);
  assign loadWe   = (state_q == LD_CAPTURE);
  assign loadSlot = SLOT_W'(index_q);
  assign loadData = fuseData;

endmodule : aot_fuse_loader

// ==== aot_pkg.sv ====
// Purpose: Shared constants for the converter offset and gain trim bank.
// Assumes: AHB-Lite register access with 32-bit data, one aligned word per register.
// Notes:   Register indices are word indices; the byte address is four times the index.
package aot_pkg;

  // ------------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------------
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int INDEX_W = 10;

  // ------------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------------
  localparam logic [INDEX_W-1:0] IDX_CORE_A_SINGLE_INA_OFFSET = 10'h348;
  localparam logic [INDEX_W-1:0] IDX_CORE_A_SINGLE_INB_OFFSET = 10'h34a;
  localparam logic [INDEX_W-1:0] IDX_CORE_B_INA_OFFSET        = 10'h34c;
  localparam logic [INDEX_W-1:0] IDX_CORE_B_INB_OFFSET        = 10'h34e;
  localparam logic [INDEX_W-1:0] IDX_CORE_A_BANK0_DUAL_GAIN   = 10'h350;
  localparam logic [INDEX_W-1:0] IDX_CORE_A_BANK1_DUAL_GAIN   = 10'h351;
  localparam logic [INDEX_W-1:0] IDX_TRIM_CTRL                = 10'h3f0;
  localparam logic [INDEX_W-1:0] IDX_TRIM_STATUS              = 10'h3f1;

  // ------------------------------------------------------------------------
  // Storage slots, shared by bus decode and fuse word numbering
  // ------------------------------------------------------------------------
  localparam int SLOT_W = 4;
  localparam logic [SLOT_W-1:0] SLOT_A_SINGLE_INA = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_A_SINGLE_INB = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_B_INA        = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_B_INB        = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_GAIN0        = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_GAIN1        = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_CTRL         = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_STATUS       = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_NONE         = 4'hf;

  localparam int NUM_OFFSET = 4;
  localparam int NUM_GAIN   = 2;
  localparam int NUM_FUSE   = 6;
  localparam int FUSE_ADDR_W = 3;
  localparam int FUSE_W     = 16;

  // ------------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------------
  localparam int OFFSET_REG_W = 16;
  localparam int OFFSET_W     = 12;
  localparam int GAIN_REG_W   = 8;
  localparam int GAIN_W       = 5;
  localparam logic [OFFSET_REG_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [GAIN_REG_W-1:0]   GAIN_RST   = 8'h00;
  localparam logic [GAIN_REG_W-1:0]   GAIN_MASK  = 8'h1f;

  localparam int CTRL_W          = 5;
  localparam int CTRL_CAL_EN_BIT = 0;
  localparam int CTRL_DUAL_BIT   = 1;
  localparam int CTRL_A_SEL_BIT  = 2;
  localparam int CTRL_B_SEL_BIT  = 3;
  localparam int CTRL_RELOAD_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_A_EN_BIT  = 1;
  localparam int STAT_B_EN_BIT  = 2;
  localparam int STAT_GAIN_BIT  = 3;

endpackage : aot_pkg

// ==== aot_trim_bank.sv ====
// Purpose: AHB-Lite trim register bank feeding offset and fine-gain corrections to two cores.
// Assumes: Single AHB-Lite slave, word transfers; fuse storage on the same clock as the bus.
// Notes:   Every transfer takes one wait state; transfers stall while fuse defaults load.
//
// Overview of operation
// - Core A takes the single-channel first-input offset while sampling the first input in single-channel mode with calibration on.
// - Core A takes the single-channel second-input offset while sampling the second input in single-channel mode with calibration on.
// - Core B takes the first-input offset at 0x34C whenever it samples the first input with calibration on, in either mode.
// - Core B takes the second-input offset at 0x34E whenever it samples the second input with calibration on, in either mode.
// - In dual-channel mode bits 4:0 at 0x350 are core A bank 0 fine gain; bits 7:5 are reserved and reset to zero.
// - In dual-channel mode bits 4:0 at 0x351 are core A bank 1 fine gain.
// - Every offset and gain register is loaded from fuse storage; upper offset bits are reserved but writable.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module aot_trim_bank
  import aot_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [DATA_W-1:0]    hwdata,
  input  wire logic                 hready,
  output logic [DATA_W-1:0]         hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Fuse storage
  output logic [FUSE_ADDR_W-1:0]    fuseAddr,
  output logic                      fuseRdEn,
  input  wire logic [FUSE_W-1:0]    fuseData,
  // Core A corrections
  output logic [OFFSET_W-1:0]       coreAOffset,
  output logic                      coreAOffsetEn,
  output logic [GAIN_W-1:0]         coreABank0Gain,
  output logic [GAIN_W-1:0]         coreABank1Gain,
  output logic                      coreAGainEn,
  // Core B corrections
  output logic [OFFSET_W-1:0]       coreBOffset,
  output logic                      coreBOffsetEn
);

  // ------------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------------
  function automatic logic [SLOT_W-1:0] slotOf(input logic [ADDR_W-1:0] addr);
    logic [INDEX_W-1:0] idx;
    idx = addr[ADDR_W-1:2];
    case (idx)
      IDX_CORE_A_SINGLE_INA_OFFSET: slotOf = SLOT_A_SINGLE_INA;
      IDX_CORE_A_SINGLE_INB_OFFSET: slotOf = SLOT_A_SINGLE_INB;
      IDX_CORE_B_INA_OFFSET:        slotOf = SLOT_B_INA;
      IDX_CORE_B_INB_OFFSET:        slotOf = SLOT_B_INB;
      IDX_CORE_A_BANK0_DUAL_GAIN:   slotOf = SLOT_GAIN0;
      IDX_CORE_A_BANK1_DUAL_GAIN:   slotOf = SLOT_GAIN1;
      IDX_TRIM_CTRL:                slotOf = SLOT_CTRL;
      IDX_TRIM_STATUS:              slotOf = SLOT_STATUS;
      default:                      slotOf = SLOT_NONE;
    endcase
  endfunction : slotOf

  // Gates an offset field so that a disabled path presents zero correction.
  function automatic logic [OFFSET_W-1:0] gatedOffset(input logic enable,
                                                      input logic [OFFSET_REG_W-1:0] word);
    gatedOffset = enable ? word[OFFSET_W-1:0] : '0;
  endfunction : gatedOffset

  // ------------------------------------------------------------------------
  // Storage and control state
  // ------------------------------------------------------------------------
  logic [OFFSET_REG_W-1:0]  offsetReg_q [NUM_OFFSET];
  logic [GAIN_REG_W-1:0]    gainReg_q   [NUM_GAIN];
  logic [CTRL_W-1:0]        ctrl_q;
  logic                     bootPending_q;
  logic                     reloadReq_q;

  logic                     dataPhase_q;
  logic                     ready_q;
  logic                     write_q;
  logic [SLOT_W-1:0]        slot_q;
  logic [DATA_W-1:0]        hrdata_q;

  logic                     loaderBusy;
  logic                     loadWe;
  logic [SLOT_W-1:0]        loadSlot;
  logic [FUSE_W-1:0]        loadData;
  logic                     loadStart;
  logic                     bankBusy;
  logic                     accept;
  logic                     busWrite;

  logic                     calEnable;
  logic                     dualMode;
  logic                     aSecondInput;
  logic                     bSecondInput;
  logic                     aSingleIna;
  logic                     aSingleInb;

  logic [OFFSET_W-1:0]      coreAOffset_q;
  logic                     coreAOffsetEn_q;
  logic [OFFSET_W-1:0]      coreBOffset_q;
  logic                     coreBOffsetEn_q;
  logic [GAIN_W-1:0]        coreABank0Gain_q;
  logic [GAIN_W-1:0]        coreABank1Gain_q;
  logic                     coreAGainEn_q;

  // ------------------------------------------------------------------------
  // Fuse default loading
  // ------------------------------------------------------------------------
  // The boot request is set during reset and taken on the first clock after it, so the loader sees a clean start after reset.
  assign loadStart = bootPending_q | reloadReq_q;
  assign bankBusy  = loaderBusy | loadStart;

  aot_fuse_loader #(
    .NUM_WORDS (NUM_FUSE)
  ) u_loader (
    .mclk      (mclk),
    .reset     (reset),
    .start     (loadStart),
    .busy      (loaderBusy),
    .fuseAddr  (fuseAddr),
    .fuseRdEn  (fuseRdEn),
    .fuseData  (fuseData),
    .loadWe    (loadWe),
    .loadSlot  (loadSlot),
    .loadData  (loadData)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      bootPending_q <= 1'b1;
    end else begin
      bootPending_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------------
  assign accept   = hsel & htrans[1] & hready;
  assign busWrite = dataPhase_q & ready_q & write_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      dataPhase_q <= 1'b0;
      write_q     <= 1'b0;
      slot_q      <= SLOT_NONE;
    end else if (hready) begin
      dataPhase_q <= accept;
      write_q     <= accept & hwrite;
      slot_q      <= accept ? slotOf(haddr) : SLOT_NONE;
    end
  end

  // One wait state per transfer, and no completion while fuse words are loading,
  // so a bus write can never collide with a fuse write.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= dataPhase_q & ~ready_q & ~bankBusy;
    end
  end

  assign hreadyout = ~dataPhase_q | ready_q;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata_q <= '0;
    end else if (dataPhase_q & ~write_q) begin
      case (slot_q)
        SLOT_A_SINGLE_INA,
        SLOT_A_SINGLE_INB,
        SLOT_B_INA,
        SLOT_B_INB: hrdata_q <= DATA_W'(offsetReg_q[slot_q[1:0]]);
        SLOT_GAIN0: hrdata_q <= DATA_W'(gainReg_q[0]);
        SLOT_GAIN1: hrdata_q <= DATA_W'(gainReg_q[1]);
        SLOT_CTRL:  hrdata_q <= DATA_W'(ctrl_q & ~(CTRL_W'(1) << CTRL_RELOAD_BIT));
        SLOT_STATUS: begin
          hrdata_q                <= '0;
          hrdata_q[STAT_BUSY_BIT] <= bankBusy;
          hrdata_q[STAT_A_EN_BIT] <= coreAOffsetEn_q;
          hrdata_q[STAT_B_EN_BIT] <= coreBOffsetEn_q;
          hrdata_q[STAT_GAIN_BIT] <= coreAGainEn_q;
        end
        default:    hrdata_q <= '0;
      endcase
    end
  end

  assign hrdata = hrdata_q;

  // ------------------------------------------------------------------------
  // Trim registers
  // ------------------------------------------------------------------------
  // Reserved upper offset bits are stored and read back like the field itself.
  for (genvar i = 0; i < NUM_OFFSET; i++) begin : g_offset
    always_ff @(posedge mclk) begin
      if (reset) begin
        offsetReg_q[i] <= OFFSET_RST;
      end else if (loadWe && loadSlot == SLOT_W'(i)) begin
        offsetReg_q[i] <= loadData;
      end else if (busWrite && slot_q == SLOT_W'(i)) begin
        offsetReg_q[i] <= hwdata[OFFSET_REG_W-1:0];
      end
    end
  end

  // Gain reserved bits 7:5 are held at zero; only the 5-bit field is stored.
  for (genvar g = 0; g < NUM_GAIN; g++) begin : g_gain
    always_ff @(posedge mclk) begin
      if (reset) begin
        gainReg_q[g] <= GAIN_RST;
      end else if (loadWe && loadSlot == SLOT_W'(NUM_OFFSET + g)) begin
        gainReg_q[g] <= loadData[GAIN_REG_W-1:0] & GAIN_MASK;
      end else if (busWrite && slot_q == SLOT_W'(NUM_OFFSET + g)) begin
        gainReg_q[g] <= hwdata[GAIN_REG_W-1:0] & GAIN_MASK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q      <= CTRL_RST;
      reloadReq_q <= 1'b0;
    end else begin
      reloadReq_q <= busWrite && slot_q == SLOT_CTRL && hwdata[CTRL_RELOAD_BIT];
      if (busWrite && slot_q == SLOT_CTRL) begin
        ctrl_q <= hwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_RELOAD_BIT);
      end
    end
  end

  // ------------------------------------------------------------------------
  // Correction selection
  // ------------------------------------------------------------------------
  assign calEnable    = ctrl_q[CTRL_CAL_EN_BIT];
  assign dualMode     = ctrl_q[CTRL_DUAL_BIT];
  assign aSecondInput = ctrl_q[CTRL_A_SEL_BIT];
  assign bSecondInput = ctrl_q[CTRL_B_SEL_BIT];

  // Core A dual-channel offsets live outside this bank, so core A gets no
  // offset correction from here in dual-channel mode, only its bank fine gains.
  assign aSingleIna = calEnable & ~dualMode & ~aSecondInput;
  assign aSingleInb = calEnable & ~dualMode &  aSecondInput;

  // Selection is re-evaluated every cycle, so any control or trim write shows
  // up on the outputs one clock after it completes.
  always_ff @(posedge mclk) begin
    if (reset) begin
      coreAOffset_q   <= '0;
      coreAOffsetEn_q <= 1'b0;
    end else begin
      coreAOffsetEn_q <= aSingleIna | aSingleInb;
      if (aSingleInb) begin
        coreAOffset_q <= gatedOffset(1'b1, offsetReg_q[SLOT_A_SINGLE_INB[1:0]]);
      end else begin
        coreAOffset_q <= gatedOffset(aSingleIna, offsetReg_q[SLOT_A_SINGLE_INA[1:0]]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      coreBOffset_q   <= '0;
      coreBOffsetEn_q <= 1'b0;
    end else begin
      coreBOffsetEn_q <= calEnable;
      if (bSecondInput) begin
        coreBOffset_q <= gatedOffset(calEnable, offsetReg_q[SLOT_B_INB[1:0]]);
      end else begin
        coreBOffset_q <= gatedOffset(calEnable, offsetReg_q[SLOT_B_INA[1:0]]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      coreABank0Gain_q <= '0;
      coreABank1Gain_q <= '0;
      coreAGainEn_q    <= 1'b0;
    end else begin
      coreAGainEn_q    <= dualMode;
      coreABank0Gain_q <= dualMode ? gainReg_q[0][GAIN_W-1:0] : '0;
      coreABank1Gain_q <= dualMode ? gainReg_q[1][GAIN_W-1:0] : '0;
    end
  end

  assign coreAOffset    = coreAOffset_q;
  assign coreAOffsetEn  = coreAOffsetEn_q;
  assign coreBOffset    = coreBOffset_q;
  assign coreBOffsetEn  = coreBOffsetEn_q;
  assign coreABank0Gain = coreABank0Gain_q;
  assign coreABank1Gain = coreABank1Gain_q;
  assign coreAGainEn    = coreAGainEn_q;

endmodule : aot_trim_bank

// ==== aot_trim_bank_props.sv ====
// Purpose: Concurrent checks on the trim bank ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/10ps
module aot_trim_bank_props
  import aot_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   reset,
  // Bus
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // Fuse storage
  input wire logic [FUSE_ADDR_W-1:0] fuseAddr,
  input wire logic                   fuseRdEn,
  // Corrections
  input wire logic [OFFSET_W-1:0]    coreAOffset,
  input wire logic                   coreAOffsetEn,
  input wire logic [GAIN_W-1:0]      coreABank0Gain,
  input wire logic [GAIN_W-1:0]      coreABank1Gain,
  input wire logic                   coreAGainEn,
  input wire logic [OFFSET_W-1:0]    coreBOffset,
  input wire logic                   coreBOffsetEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------------
  property p_reset_quiet;
    $fell(reset) |-> hreadyout && !fuseRdEn && !coreAOffsetEn && !coreBOffsetEn && !coreAGainEn;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
  property p_load_start;
    $fell(reset) |-> ##[1:4] (fuseRdEn && fuseAddr == 3'h0);
  endproperty
  a_load_start: assert property (p_load_start) else $error("fuse load did not start");
  property p_fuse_pulse;
    fuseRdEn |=> !fuseRdEn;
  endproperty
  a_fuse_pulse: assert property (p_fuse_pulse) else $error("fuse read longer than one cycle");
  property p_fuse_order;
    fuseRdEn && fuseAddr != 3'h5 |-> ##2 (fuseRdEn && fuseAddr == $past(fuseAddr, 2) + 3'h1);
  endproperty
  a_fuse_order: assert property (p_fuse_order) else $error("fuse word order broken");
  property p_ready_bound;
    !hreadyout |-> ##[1:40] hreadyout;
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("bus stalled too long");
  property p_a_off_zero;
    !coreAOffsetEn |-> coreAOffset == '0 && hresp == 1'b0;
  endproperty
  a_a_off_zero: assert property (p_a_off_zero) else $error("core A offset without enable");
  property p_a_single_only;
    coreAGainEn |-> !coreAOffsetEn;
  endproperty
  a_a_single_only: assert property (p_a_single_only) else $error("core A offset in dual mode");
  property p_b_off_zero;
    !coreBOffsetEn |-> coreBOffset == '0;
  endproperty
  a_b_off_zero: assert property (p_b_off_zero) else $error("core B offset without enable");
  property p_b_change;
    !$stable(coreBOffset) && $stable(coreBOffsetEn) |-> coreBOffsetEn;
  endproperty
  a_b_change: assert property (p_b_change) else $error("core B offset moved while off");
  property p_gain0_zero;
    !coreAGainEn |-> coreABank0Gain == '0;
  endproperty
  a_gain0_zero: assert property (p_gain0_zero) else $error("bank 0 gain outside dual");
  property p_gain1_zero;
    !coreAGainEn |-> coreABank1Gain == '0;
  endproperty
  a_gain1_zero: assert property (p_gain1_zero) else $error("bank 1 gain outside dual");

  c_a_offset: cover property (coreAOffsetEn);
  c_dual_b:   cover property (coreAGainEn && coreBOffsetEn);
  c_last_fuse: cover property (fuseRdEn && fuseAddr == 3'h5);
endmodule : aot_trim_bank_props

// ==== tb_aot_trim_bank.sv ====
// Purpose: Self-checking bench for the trim bank over AHB-Lite.
// Assumes: Bench answers fuse reads one cycle after each request.
// Notes:   Fuse data toggles when no read is pending so stale data is never reused.
`timescale 1ns/10ps
module tb_aot_trim_bank;
  import aot_pkg::*;
  logic                   mclk, reset, hsel, hwrite, hreadyout, hresp;
  logic [ADDR_W-1:0]      haddr;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [DATA_W-1:0]      hwdata, hrdata, rd;
  logic                   fuseRdEn, coreAOffsetEn, coreAGainEn, coreBOffsetEn;
  logic [FUSE_ADDR_W-1:0] fuseAddr;
  logic [FUSE_W-1:0]      fuseData = '0;
  logic [OFFSET_W-1:0]    coreAOffset, coreBOffset;
  logic [GAIN_W-1:0]      coreABank0Gain, coreABank1Gain;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  logic [FUSE_W-1:0]      fuseMem [NUM_FUSE] = '{16'h9a31, 16'h4c72, 16'hb5e3, 16'h2d94,
                                                 16'h00f5, 16'h0036};
  logic [INDEX_W-1:0]     regIdx [NUM_FUSE] = '{IDX_CORE_A_SINGLE_INA_OFFSET,
    IDX_CORE_A_SINGLE_INB_OFFSET, IDX_CORE_B_INA_OFFSET, IDX_CORE_B_INB_OFFSET,
    IDX_CORE_A_BANK0_DUAL_GAIN, IDX_CORE_A_BANK1_DUAL_GAIN};
  logic [31:0]            shadow [NUM_FUSE];

  aot_trim_bank i_dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fuseAddr(fuseAddr),
    .fuseRdEn(fuseRdEn), .fuseData(fuseData), .coreAOffset(coreAOffset),
    .coreAOffsetEn(coreAOffsetEn), .coreABank0Gain(coreABank0Gain),
    .coreABank1Gain(coreABank1Gain), .coreAGainEn(coreAGainEn),
    .coreBOffset(coreBOffset), .coreBOffsetEn(coreBOffsetEn));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) fuseData <= fuseRdEn ? fuseMem[fuseAddr] : ~fuseData;

  // ------------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------------
  function automatic logic [31:0] keep(input int i, input logic [31:0] v);
    return (i < NUM_OFFSET) ? (v & 32'h0000ffff) : (v & 32'h0000001f);
  endfunction : keep

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [INDEX_W-1:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic read_all(input string what);
    for (int i = 0; i < NUM_FUSE; i++) begin
      bus(1'b0, regIdx[i], 32'h0);
      chk(what, rd, shadow[i]);
    end
  endtask : read_all

  // ------------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------------
  task automatic t_defaults();
    for (int i = 0; i < NUM_FUSE; i++) shadow[i] = keep(i, {16'h0, fuseMem[i]});
    read_all("fuse default");
    bus(1'b1, 10'h200, 32'h1234);
    bus(1'b0, 10'h200, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask : t_defaults

  task automatic t_reserved();
    logic [31:0] vals [NUM_FUSE] = '{32'h1abc, 32'h2def, 32'h3123, 32'h4456, 32'h0e9, 32'h0f7};
    for (int i = 0; i < NUM_FUSE; i++) begin
      bus(1'b1, regIdx[i], 32'hffffffff);
      bus(1'b0, regIdx[i], 32'h0);
      chk("reserved bits", rd, keep(i, 32'hffffffff));
      bus(1'b1, regIdx[i], vals[i]);
      shadow[i] = keep(i, vals[i]);
    end
    read_all("readback");
  endtask : t_reserved

  task automatic t_select();
    logic cal, dual;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, IDX_TRIM_CTRL, 32'(c));
      repeat (2) @(posedge mclk);
      cal  = c[0];
      dual = c[1];
      chk("A enable", coreAOffsetEn, cal & ~dual);
      chk("A offset", coreAOffset, (cal & ~dual) ? shadow[c[2]][11:0] : 12'h0);
      chk("B enable", coreBOffsetEn, cal);
      chk("B offset", coreBOffset, cal ? shadow[2 + c[3]][11:0] : 12'h0);
      chk("gain enable", coreAGainEn, dual);
      chk("gain 0", coreABank0Gain, dual ? shadow[4][4:0] : 5'h0);
      chk("gain 1", coreABank1Gain, dual ? shadow[5][4:0] : 5'h0);
      bus(1'b0, IDX_TRIM_STATUS, 32'h0);
      chk("status", rd, {28'h0, dual, cal, cal & ~dual, 1'b0});
      bus(1'b0, IDX_TRIM_CTRL, 32'h0);
      chk("control", rd, 32'(c));
    end
  endtask : t_select

  task automatic t_reload();
    bus(1'b1, IDX_TRIM_CTRL, 32'h11);
    do bus(1'b0, IDX_TRIM_STATUS, 32'h0); while (rd[0] !== 1'b0);
    for (int i = 0; i < NUM_FUSE; i++) shadow[i] = keep(i, {16'h0, fuseMem[i]});
    read_all("reload");
    chk("A offset after reload", coreAOffset, fuseMem[0][11:0]);
  endtask : t_reload

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    reset  = 1'b1;
    hsel   = 1'b0;
    haddr  = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_defaults();
    t_reserved();
    t_select();
    t_reload();
    stop_test();
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule : tb_aot_trim_bank

bind aot_trim_bank aot_trim_bank_props i_props (.mclk(mclk), .reset(reset),
  .hreadyout(hreadyout), .hresp(hresp), .fuseAddr(fuseAddr), .fuseRdEn(fuseRdEn),
  .coreAOffset(coreAOffset), .coreAOffsetEn(coreAOffsetEn), .coreABank0Gain(coreABank0Gain),
  .coreABank1Gain(coreABank1Gain), .coreAGainEn(coreAGainEn), .coreBOffset(coreBOffset),
  .coreBOffsetEn(coreBOffsetEn));
